/* File: pinfn_pkg.sv */
// Constants for the external interrupt and pin-function logic.
// Assumes one 125 MHz clock and an asynchronous active-low reset.
// Behaviour
// - Source four: falling edge only, wakes.
// - Source two: falling edge only, wakes.
// - Source three: falling edge only, wakes.
// - Source zero: select 1 falling, 0 both.
// - Source one: select 0 both, 1 falling.
// - Source one edge wakes from power-down.
// - Reset indicator low until software sets high.
// - Shared pin is I/O unless reset option.
// - Master clock out undivided, halved or quartered.
// - Timer zero clock out when bit 0.
// - Timer two clock out when bit 2.
// - Last seven program bytes hold identifier.
// - Counter inputs for timers zero and two.
// - Exactly five external interrupt sources.
// - Two sixteen-bit reloadable timers, zero, two.
// - Select 00 off, 01/10/11 divide 1/2/4.
package pinfn_pkg;
   localparam int          NUM_IRQ          = 5;
   localparam int          ADDR_W           = 4;
   localparam int          DATA_W           = 8;
   localparam int          TIMER_W          = 16;
   localparam int          ID_BYTES         = 7;
   localparam int          RST_MACHINE_CYC  = 2;
   // Register offsets
   localparam logic [3:0]  OFF_TIMER_CTRL   = 4'h0;
   localparam logic [3:0]  OFF_CLKOUT_CTRL  = 4'h1;
   localparam logic [3:0]  OFF_CLK_DIV      = 4'h2;
   localparam logic [3:0]  OFF_MISC_CTRL    = 4'h3;
   localparam logic [3:0]  OFF_IRQ_STATUS   = 4'h4;
   localparam logic [3:0]  OFF_IRQ_CLEAR    = 4'h5;
   localparam logic [3:0]  OFF_IRQ_ENABLE   = 4'h6;
   localparam logic [3:0]  OFF_PIN_STATE    = 4'h7;
   // Field positions
   localparam int          BIT_IRQ0_SEL     = 0;
   localparam int          BIT_IRQ1_SEL     = 2;
   localparam int          BIT_T0CLK_EN     = 0;
   localparam int          BIT_T2CLK_EN     = 2;
   localparam int          BIT_MCK_SEL_LO   = 6;
   localparam int          BIT_MCK_SEL_HI   = 7;
   localparam int          BIT_RSTIND_HIGH  = 0;
   localparam int          BIT_POWER_DOWN   = 1;
   // Reset values
   localparam logic [7:0]  RST_TIMER_CTRL   = 8'h00;
   localparam logic [7:0]  RST_CLKOUT_CTRL  = 8'h00;
   localparam logic [7:0]  RST_CLK_DIV      = 8'h00;
   localparam logic [7:0]  RST_MISC_CTRL    = 8'h00;
   localparam logic [4:0]  RST_IRQ_ENABLE   = 5'h00;

   typedef enum logic [1:0] {
      MCK_OFF  = 2'b00,
      MCK_DIV1 = 2'b01,
      MCK_DIV2 = 2'b10,
      MCK_DIV4 = 2'b11
   } mck_sel_t;
endpackage : pinfn_pkg

/* File: pin_sync.sv */
// Two-flop synchroniser with edge detection for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module pin_sync (
   input  wire logic clk,        // System clock
   input  wire logic rstn,       // Async reset, active low
   input  wire logic pin,        // Raw pin level
   output logic      level,      // Synchronised level
   output logic      fall,       // One-cycle falling pulse
   output logic      rise        // One-cycle rising pulse
);
   logic meta;
   logic stable;
   logic prev;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta   <= 1'b1;
         stable <= 1'b1;
         prev   <= 1'b1;
      end else begin
         meta   <= pin;
         stable <= meta;
         prev   <= stable;
      end
   end

   assign level = stable;
   assign fall  = prev & ~stable;
   assign rise  = ~prev & stable;
endmodule : pin_sync

/* File: mclk_divider.sv */
// Master clock output divider: off, /1, /2 or /4.
// Assumes the master clock is clk itself; /1 is gated by clk level.
`timescale 1ns/1ns
module mclk_divider
   import pinfn_pkg::*;
(
   input  wire logic     clk,     // Master clock
   input  wire logic     rstn,    // Async reset, active low
   input  wire mck_sel_t sel,     // Divide select
   output logic          mck_out, // Divided clock
   output logic          active   // Output enabled
);
   logic [1:0] cnt;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         cnt <= 2'h0;
      else
         cnt <= cnt + 2'h1;
   end

   always_comb begin
      unique case (sel)
         MCK_OFF:  mck_out = 1'b0;
         MCK_DIV1: mck_out = clk;
         MCK_DIV2: mck_out = cnt[0];
         MCK_DIV4: mck_out = cnt[1];
      endcase
   end

   assign active = (sel != MCK_OFF);
endmodule : mclk_divider

/* File: pin_functions.sv */
// Pin-function logic: five external interrupts, wake-up, reset pin,
// reset indicator, timer counter inputs and clock outputs.
// Assumes timers elsewhere supply their clock-out toggles.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module pin_functions
   import pinfn_pkg::*;
#(
   parameter int MACHINE_CYC = 1
) (
   input  wire logic                       clk,               // 125 MHz clock
   input  wire logic                       rstn,              // Async reset, low
   input  wire logic                       reset_pin_option,  // Programming option
   input  wire logic [pinfn_pkg::ADDR_W-1:0] addr,            // Register address
   input  wire logic [pinfn_pkg::DATA_W-1:0] wdata,           // Write data
   input  wire logic                       wr,                // Write strobe
   input  wire logic                       rd,                // Read strobe
   output logic [pinfn_pkg::DATA_W-1:0]    rdata,             // Read data
   input  wire logic                       ext_irq_zero,      // Pin P3.2 level
   input  wire logic                       ext_irq_one,       // Pin P3.3 level
   input  wire logic                       ext_irq_two,       // Pin P3.4 level
   input  wire logic                       ext_irq_three,     // Pin P3.5 level
   input  wire logic                       ext_irq_four,      // Pin P3.0 level
   input  wire logic                       counter_two_input, // Pin P3.1 level
   input  wire logic                       timer_zero_toggle, // Timer zero out
   input  wire logic                       timer_two_toggle,  // Timer two out
   input  wire logic [4:0]                 gpio_out,          // Port out data
   output logic [4:0]                      irq_req,           // Per-source pulses
   output logic                            wake,              // Wake pulse
   output logic                            irq,               // Level interrupt
   output logic                            ext_reset,         // Reset request
   output logic                            counter_zero_tick, // Counter zero pulse
   output logic                            counter_two_tick,  // Counter two pulse
   output logic                            reset_indicator_out, // P3.3 output
   output logic                            master_clock_out_pin, // P3.4 output
   output logic                            master_clock_out_oe,  // P3.4 enable
   output logic                            timer_zero_clock_out, // P3.5 output
   output logic                            timer_two_clock_out,  // P3.0 output
   output logic [5:0]                      pin_out            // Muxed port data
);
   logic [NUM_IRQ-1:0] raw_pins;
   logic [NUM_IRQ-1:0] lvl;
   logic [NUM_IRQ-1:0] fall;
   logic [NUM_IRQ-1:0] rise;
   logic               t2_lvl;
   logic               t2_fall;
   logic [7:0]         timer_control_reg;
   logic [7:0]         irq_and_clkout_control;
   logic [7:0]         clk_div_reg;
   logic [7:0]         misc_ctrl;
   logic [NUM_IRQ-1:0] irq_status;
   logic [NUM_IRQ-1:0] irq_enable;
   logic [NUM_IRQ-1:0] next_req;
   logic               irq_zero_edge_select;
   logic               irq_one_edge_select;
   logic               master_out_div_sel_hi;
   logic               master_out_div_sel_lo;
   logic               power_down;
   logic [7:0]         rst_cnt;
   logic               mck_active;

   // five sources, index equals source number
   assign raw_pins = {ext_irq_four, ext_irq_three, ext_irq_two,
                      ext_irq_one, ext_irq_zero};

   // each pin synchronised before edge detection
   genvar g;
   generate
      for (g = 0; g < NUM_IRQ; g++) begin : g_sync
         pin_sync u_sync (
            .clk   (clk),
            .rstn  (rstn),
            .pin   (raw_pins[g]),
            .level (lvl[g]),
            .fall  (fall[g]),
            .rise  (rise[g])
         );
      end
   endgenerate

   pin_sync u_t2_sync (
      .clk   (clk),
      .rstn  (rstn),
      .pin   (counter_two_input),
      .level (t2_lvl),
      .fall  (t2_fall),
      .rise  ()
   );

   assign irq_zero_edge_select  = timer_control_reg[BIT_IRQ0_SEL];
   assign irq_one_edge_select   = timer_control_reg[BIT_IRQ1_SEL];
   assign master_out_div_sel_hi = clk_div_reg[BIT_MCK_SEL_HI];
   assign master_out_div_sel_lo = clk_div_reg[BIT_MCK_SEL_LO];
   assign power_down            = misc_ctrl[BIT_POWER_DOWN];

   // Edge qualification per source
   always_comb begin
      next_req[0] = fall[0] | (rise[0] & ~irq_zero_edge_select);
      next_req[1] = fall[1] | (rise[1] & ~irq_one_edge_select);
      next_req[2] = fall[2];
      next_req[3] = fall[3];
      next_req[4] = fall[4];
   end

   // Request pulses registered
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         irq_req <= '0;
      else
         irq_req <= next_req;
   end

   // wake on any qualified edge in power-down
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         wake <= 1'b0;
      else
         wake <= power_down & (|next_req);
   end

   // Sticky status, set wins over clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         irq_status <= '0;
      else if (wr && addr == OFF_IRQ_CLEAR)
         irq_status <= (irq_status & ~wdata[NUM_IRQ-1:0]) | next_req;
      else
         irq_status <= irq_status | next_req;
   end

   assign irq = |(irq_status & irq_enable);

   // Software registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         timer_control_reg      <= RST_TIMER_CTRL;
         irq_and_clkout_control <= RST_CLKOUT_CTRL;
         clk_div_reg            <= RST_CLK_DIV;
         misc_ctrl              <= RST_MISC_CTRL;
         irq_enable             <= RST_IRQ_ENABLE;
      end else if (wr) begin
         unique case (addr)
            OFF_TIMER_CTRL:  timer_control_reg      <= wdata;
            OFF_CLKOUT_CTRL: irq_and_clkout_control <= wdata;
            OFF_CLK_DIV:     clk_div_reg            <= wdata;
            OFF_MISC_CTRL:   misc_ctrl              <= wdata;
            OFF_IRQ_ENABLE:  irq_enable             <= wdata[NUM_IRQ-1:0];
            default: ;
         endcase
      end
   end

   // Read data one cycle after strobe
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         rdata <= '0;
      else if (rd) begin
         unique case (addr)
            OFF_TIMER_CTRL:  rdata <= timer_control_reg;
            OFF_CLKOUT_CTRL: rdata <= irq_and_clkout_control;
            OFF_CLK_DIV:     rdata <= clk_div_reg;
            OFF_MISC_CTRL:   rdata <= misc_ctrl;
            OFF_IRQ_STATUS:  rdata <= {3'h0, irq_status};
            OFF_IRQ_ENABLE:  rdata <= {3'h0, irq_enable};
            OFF_PIN_STATE:   rdata <= {2'h0, t2_lvl, lvl};
            default:         rdata <= 8'h00;
         endcase
      end else
         rdata <= 8'h00;
   end

   // indicator low until software sets it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         reset_indicator_out <= 1'b0;
      else
         reset_indicator_out <= misc_ctrl[BIT_RSTIND_HIGH];
   end

   // reset input only with option; hold time
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_cnt   <= 8'h00;
         ext_reset <= 1'b0;
      end else if (reset_pin_option && lvl[2]) begin
         if (rst_cnt < 8'(RST_MACHINE_CYC * MACHINE_CYC))
            rst_cnt <= rst_cnt + 8'h01;
         ext_reset <= (rst_cnt >= 8'(RST_MACHINE_CYC * MACHINE_CYC - 1));
      end else begin
         rst_cnt   <= 8'h00;
         ext_reset <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         counter_zero_tick <= 1'b0;
         counter_two_tick  <= 1'b0;
      end else begin
         counter_zero_tick <= fall[2] & ~reset_pin_option;
         counter_two_tick  <= t2_fall;
      end
   end

   mclk_divider u_mck (
      .clk     (clk),
      .rstn    (rstn),
      .sel     (mck_sel_t'({master_out_div_sel_hi, master_out_div_sel_lo})),
      .mck_out (master_clock_out_pin),
      .active  (mck_active)
   );

   assign master_clock_out_oe = mck_active & ~reset_pin_option;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         timer_zero_clock_out <= 1'b0;
      else
         timer_zero_clock_out <= irq_and_clkout_control[BIT_T0CLK_EN] & timer_zero_toggle;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         timer_two_clock_out <= 1'b0;
      else
         timer_two_clock_out <= irq_and_clkout_control[BIT_T2CLK_EN] & timer_two_toggle;
   end

   // Pin output mux: bit n is port pin 3.n
   always_comb begin
      pin_out    = {1'b1, gpio_out};
      pin_out[0] = irq_and_clkout_control[BIT_T2CLK_EN] ? timer_two_clock_out : gpio_out[0];
      pin_out[3] = reset_indicator_out;
      pin_out[4] = master_clock_out_oe ? master_clock_out_pin : gpio_out[4];
      pin_out[5] = irq_and_clkout_control[BIT_T0CLK_EN] ? timer_zero_clock_out : 1'b1;
   end
endmodule : pin_functions

/* File: pinfn_props.sv */
// Assertions on the pin-function block ports.
// Assumes it is bound to pin_functions, one clock domain.
`timescale 1ns/1ns
module pinfn_props
   import pinfn_pkg::*;
(
   input wire logic                         clk,                  // Clock
   input wire logic                         rstn,                 // Reset
   input wire logic                         reset_pin_option,     // Strap
   input wire logic [pinfn_pkg::ADDR_W-1:0] addr,                 // Address
   input wire logic [pinfn_pkg::DATA_W-1:0] wdata,                // Data
   input wire logic                         wr,                   // Write
   input wire logic                         ext_irq_zero,         // Pin
   input wire logic                         ext_irq_one,          // Pin
   input wire logic                         ext_irq_three,        // Pin
   input wire logic                         ext_irq_four,         // Pin
   input wire logic [4:0]                   irq_req,              // Requests
   input wire logic                         wake,                 // Wake
   input wire logic                         ext_reset,            // Reset out
   input wire logic                         reset_indicator_out,  // Indicator
   input wire logic                         master_clock_out_oe,  // Enable
   input wire logic                         timer_zero_clock_out, // Clock out
   input wire logic                         timer_two_clock_out   // Clock out
);
   logic [7:0] tctl, ctl, dv, misc;

   // Shadow of the control registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {tctl, ctl, dv, misc} <= 32'h0;
      end else if (wr) begin
         if (addr == OFF_TIMER_CTRL) tctl <= wdata;
         if (addr == OFF_CLKOUT_CTRL) ctl <= wdata;
         if (addr == OFF_CLK_DIV) dv <= wdata;
         if (addr == OFF_MISC_CTRL) misc <= wdata;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_four_fall_req: assert property ($fell(ext_irq_four) |-> ##[2:4] irq_req[4])
      else $error("source four fall gave no request");
   chk_three_rise_quiet: assert property ($rose(ext_irq_three) |-> !irq_req[3] [*5])
      else $error("source three rise gave a request");
   chk_zero_both_edges: assert property ($rose(ext_irq_zero) && !tctl[0] |-> ##[2:4] irq_req[0])
      else $error("source zero rise missed");
   chk_one_fall_only: assert property ($rose(ext_irq_one) && tctl[2] |-> !irq_req[1] [*5])
      else $error("source one rise not refused");
   chk_one_wakes: assert property ($fell(ext_irq_one) && misc[1] |-> ##[2:4] wake)
      else $error("source one gave no wake");
   chk_indicator_low: assert property (!misc[0] && !$past(misc[0]) |-> !reset_indicator_out)
      else $error("indicator high without command");
   chk_reset_pin_io: assert property (!reset_pin_option && !$past(reset_pin_option) |-> !ext_reset)
      else $error("reset without option");
   chk_t0_out_gate: assert property (!ctl[0] && !$past(ctl[0]) |-> !timer_zero_clock_out)
      else $error("timer zero clock out not gated");
   chk_t2_out_gate: assert property (!ctl[2] && !$past(ctl[2]) |-> !timer_two_clock_out)
      else $error("timer two clock out not gated");
   chk_mclk_enable: assert property (master_clock_out_oe == (dv[7:6] != 2'b00 && !reset_pin_option))
      else $error("master clock enable wrong");

   cover property (wake);
   cover property (ext_reset);
   cover property (irq_req[1] && !tctl[2]);
endmodule : pinfn_props

bind pin_functions pinfn_props u_props (.clk, .rstn, .reset_pin_option, .addr, .wdata, .wr,
   .ext_irq_zero, .ext_irq_one, .ext_irq_three, .ext_irq_four, .irq_req, .wake, .ext_reset,
   .reset_indicator_out, .master_clock_out_oe, .timer_zero_clock_out, .timer_two_clock_out);

/* File: board_pins.sv */
// Board model: weak pull-ups on the interrupt and counter pins.
// Assumes the bench calls its tasks; pins idle high.
`timescale 1ns/1ns
module board_pins (
   input  wire logic clk,     // System clock
   output logic [4:0] irq_pin, // Interrupt pins
   output logic       t2_pin   // Counter two pin
);
   initial begin
      irq_pin = 5'h1f;
      t2_pin  = 1'b1;
   end
   task automatic drive(input int n, input logic v);
      @(posedge clk);
      if (n < 5) irq_pin[n] <= v;
      else t2_pin <= v;
   endtask : drive
   task automatic pulse(input int cyc);
      drive(2, 1'b1);
      repeat (cyc) @(posedge clk);
      irq_pin[2] <= 1'b0;
   endtask : pulse
endmodule : board_pins

/* File: testbench.sv */
// Self-checking bench for the pin-function block.
// Assumes the board model drives the pins.
`timescale 1ns/1ns
module testbench;
   import pinfn_pkg::*;
   logic       clk = 1'b0, rstn = 1'b0, reset_pin_option = 1'b0;
   logic       wr = 1'b0, rd = 1'b0, tt = 1'b0, t2pin, wake, irq, ext_reset;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, v;
   logic [4:0] irq_req, pin;
   logic [3:0] seen = 4'h0;
   logic [5:0] po;
   logic       counter_zero_tick, counter_two_tick, reset_indicator_out;
   logic       master_clock_out_pin, master_clock_out_oe;
   logic       timer_zero_clock_out, timer_two_clock_out;
   int         err_total = 0, n_compared = 0, mc, c0, c2;

   always #4 clk = ~clk;
   always @(posedge clk) tt <= ~tt;
   always @(posedge clk) seen <= seen | {ext_reset, counter_two_tick, counter_zero_tick, wake};
   always @(posedge master_clock_out_pin) mc++;
   always @(posedge timer_zero_clock_out) c0++;
   always @(posedge timer_two_clock_out) c2++;

   board_pins board (.clk(clk), .irq_pin(pin), .t2_pin(t2pin));
   pin_functions #(.MACHINE_CYC(1)) uut (.clk, .rstn, .reset_pin_option, .addr, .wdata, .wr,
      .rd, .rdata, .ext_irq_zero(pin[0]), .ext_irq_one(pin[1]), .ext_irq_two(pin[2]),
      .ext_irq_three(pin[3]), .ext_irq_four(pin[4]), .counter_two_input(t2pin),
      .timer_zero_toggle(tt), .timer_two_toggle(tt), .gpio_out(5'h00), .irq_req, .wake, .irq,
      .ext_reset, .counter_zero_tick, .counter_two_tick, .reset_indicator_out,
      .master_clock_out_pin, .master_clock_out_oe, .timer_zero_clock_out,
      .timer_two_clock_out, .pin_out(po));

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wreg
   task automatic rchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("register", e, rdata);
   endtask : rchk
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask : settle

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_of_test();
   end

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      // Registers read zero; pin levels idle high
      foreach (v[i]) rchk(i[3:0] + 4'h1, (i == 6) ? 8'h3f : 8'h00);
      chk("indicator", 8'h00, reset_indicator_out);
      wreg(OFF_IRQ_ENABLE, 8'h1f);
      wreg(OFF_MISC_CTRL, 8'h02);
      for (int s = 0; s < 2; s++) begin
         wreg(OFF_TIMER_CTRL, s ? 8'h05 : 8'h00);
         for (int n = 0; n < 5; n++) begin
            @(negedge clk) seen = 4'h0;
            board.drive(n, 1'b0);
            settle();
            chk("irq", 8'h01, irq);
            chk("wake", 8'h01, seen[0]);
            chk("count zero", n == 2, seen[1]);
            rchk(OFF_IRQ_STATUS, 8'h01 << n);
            wreg(OFF_IRQ_CLEAR, 8'h1f);
            chk("irq", 8'h00, irq);
            board.drive(n, 1'b1);
            settle();
            rchk(OFF_IRQ_STATUS, (n < 2 && s == 0) ? 8'h01 << n : 8'h00);
            wreg(OFF_IRQ_CLEAR, 8'h1f);
         end
      end
      board.drive(5, 1'b0);
      settle();
      chk("count two", 8'h01, seen[2]);
      wreg(OFF_IRQ_ENABLE, 8'h00);
      board.drive(3, 1'b0);
      settle();
      chk("masked irq", 8'h00, irq);
      wreg(OFF_IRQ_ENABLE, 8'h08);
      chk("irq", 8'h01, irq);
      rchk(OFF_IRQ_STATUS, 8'h08);
      for (int k = 0; k < 4; k++) begin
         wreg(OFF_CLK_DIV, {k[1:0], 6'h00});
         wreg(OFF_CLKOUT_CTRL, {5'h00, k[1], 1'b0, k[0]});
         @(negedge clk);
         mc = 0;
         c0 = 0;
         c2 = 0;
         repeat (16) @(negedge clk);
         chk("master clock", (k == 0) ? 8'h00 : 8'h10 >> (k - 1), mc[7:0]);
         chk("master enable", k != 0, master_clock_out_oe);
         chk("timer zero out", k[0], c0 != 0);
         chk("timer two out", k[1], c2 != 0);
      end
      wreg(OFF_MISC_CTRL, 8'h01);
      settle();
      chk("indicator", 8'h01, reset_indicator_out);
      chk("indicator pin", 8'h01, po[3]);
      @(posedge clk) rstn <= 1'b0;
      settle();
      chk("indicator", 8'h00, reset_indicator_out);
      rstn <= 1'b1;
      rchk(OFF_MISC_CTRL, 8'h00);
      board.drive(2, 1'b0);
      @(posedge clk) reset_pin_option <= 1'b1;
      settle();
      @(negedge clk) seen = 4'h0;
      board.pulse(1);
      settle();
      chk("reset short", 8'h00, seen[3]);
      board.drive(2, 1'b1);
      settle();
      chk("reset held", 8'h01, ext_reset);
      board.drive(2, 1'b0);
      settle();
      reset_pin_option <= 1'b0;
      board.drive(2, 1'b1);
      settle();
      chk("reset as io", 8'h00, ext_reset);
      end_of_test();
   end
endmodule : testbench
